// File: src/uart_shadow_data_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// - sixteen aliased word addresses all reach the same receive/transmit data byte
// - low-byte read returns received character, serial or infrared source
// - fifos off: unread character overwritten by new one, overrun flagged
// - fifos on: read returns head entry of receive fifo
// - receive fifo full: new character dropped, contents kept, overrun flagged
// - low-byte write queues character for serial or infrared output
// - fifos off: one write clears transmit holding empty flag
// - fifos off: further writes before flag sets again replace pending character
// - fifos on: up to depth writes accepted before transmit fifo full
// - write while transmit fifo full is discarded, fifo unchanged
module uart_shadow_data_port
  import uart_shadow_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH_DEF
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RX_SER_VALID,
  input  wire logic [7:0]  RX_SER_DATA,
  input  wire logic        RX_IR_VALID,
  input  wire logic [7:0]  RX_IR_DATA,
  output logic             TX_SER_VALID,
  output logic             TX_IR_VALID,
  output logic      [7:0]  TX_DATA,
  input  wire logic        TX_READY,
  output logic             IRQ
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic              rst_s1_q;
  logic              rst_n;
  logic              pready_q;
  logic              pslverr_q;
  logic [31:0]       prdata_q;
  logic              fifo_en_q;
  logic              ir_mode_q;
  logic [IRQ_W-1:0]  irq_st_q;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic              irq_q;
  logic [7:0]        rx_mem [DEPTH];
  logic [AW-1:0]     rx_wr_q;
  logic [AW-1:0]     rx_rd_q;
  logic [CW-1:0]     rx_cnt_q;
  logic [7:0]        rx_hold_q;
  logic              rx_hold_full_q;
  logic              overrun_q;
  logic              rd_pend_q;
  logic [7:0]        tx_mem [DEPTH];
  logic [AW-1:0]     tx_wr_q;
  logic [AW-1:0]     tx_rd_q;
  logic [CW-1:0]     tx_cnt_q;
  logic [7:0]        tx_hold_q;
  logic              tx_hold_full_q;
  logic              tx_ser_q;
  logic              tx_ir_q;
  logic [7:0]        tx_data_q;
  logic              dr_prev_q;
  logic              tx_holding_empty_flag_prev_q;

  logic              setup;
  logic              acc;
  logic [31:0]       alias_off;
  logic              alias_hit;
  logic              reg_hit;
  logic              rd_alias;
  logic              wr_alias;
  logic              ctrl_wr;
  logic              flush;
  logic              rx_in_valid;
  logic [7:0]        rx_in_data;
  logic              rx_full;
  logic              rx_pop;
  logic              rx_push;
  logic              oe_set;
  logic              dr;
  logic [7:0]        rx_head;
  logic              tx_full;
  logic              tx_push;
  logic              tx_load;
  logic              tx_pop;
  logic [7:0]        tx_head;
  logic              tx_holding_empty_flag;
  logic [IRQ_W-1:0]  irq_ev;
  logic [31:0]       rdata;

  // reset released through two flops
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // address decode; alias window is word aligned, 16 words
  assign setup     = PSEL & ~PENABLE;
  assign acc       = PSEL & PENABLE & pready_q;
  assign alias_off = PADDR - ALIAS_BASE_ADDR;
  assign alias_hit = (alias_off < ALIAS_SPAN) && (PADDR[1:0] == 2'b00);
  assign reg_hit   = (PADDR == CTRL_ADDR) || (PADDR == LINE_STATUS_ADDR) ||
                     (PADDR == IRQ_STATUS_ADDR) || (PADDR == IRQ_MASK_ADDR);
  assign rd_alias  = acc & ~PWRITE & alias_hit;
  assign wr_alias  = acc & PWRITE & alias_hit;
  assign ctrl_wr   = acc & PWRITE & (PADDR == CTRL_ADDR);
  // toggling fifo mode empties both fifos by clearing their pointers and counts
  assign flush     = ctrl_wr & (PWDATA[FIFO_EN_BIT] != fifo_en_q);

  // receive side
  assign rx_in_valid = ir_mode_q ? RX_IR_VALID : RX_SER_VALID;
  assign rx_in_data  = ir_mode_q ? RX_IR_DATA : RX_SER_DATA;
  assign rx_full     = (rx_cnt_q == FULL_CNT);
  assign rx_pop      = rd_alias & rd_pend_q;
  assign rx_push     = fifo_en_q & rx_in_valid & (~rx_full | rx_pop);
  assign oe_set      = rx_in_valid & (fifo_en_q ? (rx_full & ~rx_pop)
                                                : (rx_hold_full_q & ~rx_pop));
  assign dr          = fifo_en_q ? (rx_cnt_q != '0) : rx_hold_full_q;
  assign rx_head     = fifo_en_q ? rx_mem[rx_rd_q] : rx_hold_q;

  // transmit side
  assign tx_full = (tx_cnt_q == FULL_CNT);
  assign tx_push = wr_alias & fifo_en_q & ~tx_full;
  assign tx_load = ~(tx_ser_q | tx_ir_q) | TX_READY;
  assign tx_pop  = tx_load & (fifo_en_q ? (tx_cnt_q != '0) : tx_hold_full_q);
  assign tx_head = fifo_en_q ? tx_mem[tx_rd_q] : tx_hold_q;
  assign tx_holding_empty_flag    = fifo_en_q ? (tx_cnt_q == '0) : ~tx_hold_full_q;

  always_comb begin
    rdata = 32'h0000_0000;
    if (alias_hit) begin
      rdata[7:0] = rx_head;
    end else if (PADDR == CTRL_ADDR) begin
      rdata[FIFO_EN_BIT] = fifo_en_q;
      rdata[IR_MODE_BIT] = ir_mode_q;
    end else if (PADDR == LINE_STATUS_ADDR) begin
      rdata[LS_DR_BIT]   = dr;
      rdata[LS_OE_BIT]   = overrun_q;
      rdata[LS_TX_HOLDING_EMPTY_FLAG_BIT] = tx_holding_empty_flag;
    end else if (PADDR == IRQ_STATUS_ADDR) begin
      rdata[IRQ_W-1:0] = irq_st_q;
    end else if (PADDR == IRQ_MASK_ADDR) begin
      rdata[IRQ_W-1:0] = irq_mask_q;
    end
  end

  // apb: zero wait states, data captured in setup, pop taken at completion
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      rd_pend_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~(alias_hit | reg_hit);
      rd_pend_q <= setup & ~PWRITE & alias_hit & dr;
      if (setup && !PWRITE) begin
        prdata_q <= rdata;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      fifo_en_q  <= 1'b0;
      ir_mode_q  <= 1'b0;
      irq_mask_q <= '0;
    end else begin
      if (ctrl_wr) begin
        fifo_en_q <= PWDATA[FIFO_EN_BIT];
        ir_mode_q <= PWDATA[IR_MODE_BIT];
      end
      if (acc && PWRITE && PADDR == IRQ_MASK_ADDR) begin
        irq_mask_q <= PWDATA[IRQ_W-1:0];
      end
    end
  end

  // receive fifo and single holding register
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_wr_q        <= '0;
      rx_rd_q        <= '0;
      rx_cnt_q       <= '0;
      rx_hold_q      <= DATA_RESET;
      rx_hold_full_q <= 1'b0;
    end else if (flush) begin
      rx_wr_q  <= '0;
      rx_rd_q  <= '0;
      rx_cnt_q <= '0;
    end else begin
      if (rx_push) begin
        rx_wr_q <= AW'(rx_wr_q + 1'b1);
      end
      if (rx_pop && fifo_en_q) begin
        rx_rd_q <= AW'(rx_rd_q + 1'b1);
      end
      if (fifo_en_q) begin
        rx_cnt_q <= rx_cnt_q + CW'(rx_push) - CW'(rx_pop);
      end
      if (!fifo_en_q && rx_in_valid) begin
        rx_hold_q      <= rx_in_data;
        rx_hold_full_q <= 1'b1;
      end else if (!fifo_en_q && rx_pop) begin
        rx_hold_full_q <= 1'b0;
      end
    end
  end

  // no reset on storage; a read of an empty receive fifo still returns the slot at its read pointer
  always_ff @(posedge SYS_CLK) begin
    if (rx_push) begin
      rx_mem[rx_wr_q] <= rx_in_data;
    end
    if (tx_push) begin
      tx_mem[tx_wr_q] <= PWDATA[7:0];
    end
  end

  // overrun clears on a line status read; a new overrun wins
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      overrun_q <= 1'b0;
    end else if (oe_set) begin
      overrun_q <= 1'b1;
    end else if (acc && !PWRITE && PADDR == LINE_STATUS_ADDR) begin
      overrun_q <= 1'b0;
    end
  end

  // transmit fifo and single holding register
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_wr_q        <= '0;
      tx_rd_q        <= '0;
      tx_cnt_q       <= '0;
      tx_hold_q      <= DATA_RESET;
      tx_hold_full_q <= 1'b0;
    end else if (flush) begin
      tx_wr_q  <= '0;
      tx_rd_q  <= '0;
      tx_cnt_q <= '0;
    end else begin
      if (tx_push) begin
        tx_wr_q <= AW'(tx_wr_q + 1'b1);
      end
      if (tx_pop && fifo_en_q) begin
        tx_rd_q <= AW'(tx_rd_q + 1'b1);
      end
      if (fifo_en_q) begin
        tx_cnt_q <= tx_cnt_q + CW'(tx_push) - CW'(tx_pop);
      end
      if (wr_alias && !fifo_en_q) begin
        tx_hold_q      <= PWDATA[7:0];
        tx_hold_full_q <= 1'b1;
      end else if (!fifo_en_q && tx_pop) begin
        tx_hold_full_q <= 1'b0;
      end
    end
  end

  // output stage to the shifter; mode is frozen per character
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_ser_q  <= 1'b0;
      tx_ir_q   <= 1'b0;
      tx_data_q <= DATA_RESET;
    end else if (tx_load) begin
      tx_ser_q <= tx_pop & ~ir_mode_q;
      tx_ir_q  <= tx_pop & ir_mode_q;
      if (tx_pop) begin
        tx_data_q <= tx_head;
      end
    end
  end

  // interrupts: sticky, write one to clear, set wins
  assign irq_ev[IRQ_RX_BIT]   = dr & ~dr_prev_q;
  assign irq_ev[IRQ_OE_BIT]   = oe_set;
  assign irq_ev[IRQ_TX_HOLDING_EMPTY_FLAG_BIT] = tx_holding_empty_flag & ~tx_holding_empty_flag_prev_q;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      dr_prev_q   <= 1'b0;
      tx_holding_empty_flag_prev_q <= 1'b1;
      irq_st_q    <= '0;
      irq_q       <= 1'b0;
    end else begin
      dr_prev_q   <= dr;
      tx_holding_empty_flag_prev_q <= tx_holding_empty_flag;
      if (acc && PWRITE && PADDR == IRQ_STATUS_ADDR) begin
        irq_st_q <= (irq_st_q & ~PWDATA[IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_st_q <= irq_st_q | irq_ev;
      end
      irq_q <= |(irq_st_q & irq_mask_q);
    end
  end

  assign PRDATA       = prdata_q;
  assign PREADY       = pready_q;
  assign PSLVERR      = pslverr_q;
  assign TX_SER_VALID = tx_ser_q;
  assign TX_IR_VALID  = tx_ir_q;
  assign TX_DATA      = tx_data_q;
  assign IRQ          = irq_q;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n);

  sequence s_tx_write;
    wr_alias && !fifo_en_q && !tx_hold_full_q && !tx_ser_q && !tx_ir_q && !flush;
  endsequence

  sequence s_tx_out;
    ##1 tx_hold_full_q ##1 (TX_SER_VALID || TX_IR_VALID) &&
      TX_DATA == $past(PWDATA[7:0], 2) && TX_IR_VALID == $past(ir_mode_q, 2);
  endsequence

  chk_alias_answer: assert property (
    setup && alias_hit |=> PREADY && !PSLVERR)
    else $error("aliased data address not answered cleanly");

  chk_rx_source: assert property (
    !fifo_en_q && ir_mode_q && RX_IR_VALID |=> rx_hold_q == $past(RX_IR_DATA))
    else $error("infrared character not captured");

  chk_rx_overwrite: assert property (
    !fifo_en_q && rx_hold_full_q && rx_in_valid && !rx_pop
    |=> overrun_q && rx_hold_q == $past(rx_in_data))
    else $error("unread character not overwritten with overrun");

  chk_fifo_head: assert property (
    setup && !PWRITE && alias_hit && fifo_en_q && rx_cnt_q != '0
    |=> PRDATA[7:0] == $past(rx_head))
    else $error("read did not return receive fifo head");

  chk_rx_full_drop: assert property (
    fifo_en_q && rx_full && rx_in_valid && !rx_pop && !flush
    |=> rx_full && overrun_q && $stable(rx_wr_q))
    else $error("full receive fifo accepted a character");

  chk_tx_queue_out: assert property (
    s_tx_write |-> s_tx_out)
    else $error("written character not presented on chosen line");

  chk_tx_holding_empty_flag_clear: assert property (
    wr_alias && !fifo_en_q && !flush |=> !tx_holding_empty_flag)
    else $error("holding empty flag not cleared by write");

  chk_tx_replace: assert property (
    wr_alias && !fifo_en_q && tx_hold_full_q && !tx_pop && !flush
    |=> tx_hold_full_q && tx_hold_q == $past(PWDATA[7:0]))
    else $error("pending transmit character not replaced");

  chk_tx_fill: assert property (
    wr_alias && fifo_en_q && !tx_full && !tx_pop && !flush
    |=> tx_cnt_q == $past(tx_cnt_q) + 1)
    else $error("transmit fifo did not take write");

  chk_tx_full_drop: assert property (
    wr_alias && fifo_en_q && tx_full && !tx_pop |=> tx_full && $stable(tx_wr_q))
    else $error("write into full transmit fifo not discarded");

  chk_upper_zero: assert property (
    setup && !PWRITE && alias_hit |=> PRDATA[31:8] == 24'h000000)
    else $error("reserved upper bits not zero");
endmodule

// File: src/uart_shadow_pkg.sv
package uart_shadow_pkg;
  localparam logic [31:0] ALIAS_BASE_ADDR  = 32'h5000_1030;
  localparam logic [31:0] ALIAS_12_ADDR    = 32'h5000_1060;
  localparam logic [31:0] ALIAS_13_ADDR    = 32'h5000_1064;
  localparam logic [31:0] ALIAS_SPAN       = 32'h0000_0040;
  localparam logic [31:0] CTRL_ADDR        = 32'h5000_1100;
  localparam logic [31:0] LINE_STATUS_ADDR = 32'h5000_1104;
  localparam logic [31:0] IRQ_STATUS_ADDR  = 32'h5000_1108;
  localparam logic [31:0] IRQ_MASK_ADDR    = 32'h5000_110C;
  localparam int          FIFO_EN_BIT      = 0;
  localparam int          IR_MODE_BIT      = 1;
  localparam int          LS_DR_BIT        = 0;
  localparam int          LS_OE_BIT        = 1;
  localparam int          LS_TX_HOLDING_EMPTY_FLAG_BIT      = 5;
  localparam int          IRQ_RX_BIT       = 0;
  localparam int          IRQ_OE_BIT       = 1;
  localparam int          IRQ_TX_HOLDING_EMPTY_FLAG_BIT     = 2;
  localparam int          IRQ_W            = 3;
  localparam logic [7:0]  DATA_RESET       = 8'h00;
  localparam int          FIFO_DEPTH_DEF   = 16;
endpackage

// File: bench/uart_far_end.sv
`timescale 1ns/1ps
module uart_far_end (
  input  wire logic       SYS_CLK,
  input  wire logic       STALL,
  input  wire logic       TX_SER_VALID,
  input  wire logic       TX_IR_VALID,
  input  wire logic [7:0] TX_DATA,
  output logic            TX_READY,
  output logic            RX_SER_VALID,
  output logic [7:0]      RX_SER_DATA,
  output logic            RX_IR_VALID,
  output logic [7:0]      RX_IR_DATA
);
  logic [8:0] got_q[$];

  initial begin
    RX_SER_VALID = 1'b0;
    RX_IR_VALID  = 1'b0;
    RX_SER_DATA  = 8'h00;
    RX_IR_DATA   = 8'h00;
  end

  // a stalled shifter holds ready low for as long as the bench asks
  assign TX_READY = !STALL;

  // one strobe per char; data lines scrambled outside the strobe so stale bytes never match
  task automatic send_char(input logic ir, input logic [7:0] d);
    @(posedge SYS_CLK);
    RX_SER_VALID <= !ir;
    RX_IR_VALID  <= ir;
    RX_SER_DATA  <= ir ? ~d : d;
    RX_IR_DATA   <= ir ? d : ~d;
    @(posedge SYS_CLK);
    RX_SER_VALID <= 1'b0;
    RX_IR_VALID  <= 1'b0;
    RX_SER_DATA  <= ~d;
    RX_IR_DATA   <= ~d;
  endtask

  // bit 8 records which line carried the char
  always @(posedge SYS_CLK) begin
    if ((TX_SER_VALID || TX_IR_VALID) && TX_READY) begin
      got_q.push_back({TX_IR_VALID, TX_DATA});
    end
  end
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import uart_shadow_pkg::*;
  localparam int DEPTH = 4;
  logic        sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, stall, irq;
  logic [31:0] paddr, pwdata, prdata, rdata;
  logic        rx_ser_valid, rx_ir_valid, tx_ser_valid, tx_ir_valid, tx_ready, serr;
  logic [7:0]  rx_ser_data, rx_ir_data, tx_data;
  int          fails, n_checks, k;

  uart_shadow_data_port #(.DEPTH(DEPTH)) uart_shadow_data_port_inst (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_SER_VALID(rx_ser_valid), .RX_SER_DATA(rx_ser_data), .RX_IR_VALID(rx_ir_valid),
    .RX_IR_DATA(rx_ir_data), .TX_SER_VALID(tx_ser_valid), .TX_IR_VALID(tx_ir_valid),
    .TX_DATA(tx_data), .TX_READY(tx_ready), .IRQ(irq));

  uart_far_end uart_far_end_inst (
    .SYS_CLK(sys_clk), .STALL(stall), .TX_SER_VALID(tx_ser_valid), .TX_IR_VALID(tx_ir_valid),
    .TX_DATA(tx_data), .TX_READY(tx_ready), .RX_SER_VALID(rx_ser_valid),
    .RX_SER_DATA(rx_ser_data), .RX_IR_VALID(rx_ir_valid), .RX_IR_DATA(rx_ir_data));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // request held until pready is sampled high, released only after that edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      fails++;
      report_and_stop();
    end
    rdata = prdata;
    serr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdata, exp);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic send(input logic ir, input logic [7:0] d);
    uart_far_end_inst.send_char(ir, d);
  endtask

  // bounded wait for the far end to collect n chars
  task automatic wait_got(input int n);
    int i;
    for (i = 0; i < 400 && uart_far_end_inst.got_q.size() < n; i++) @(posedge sys_clk);
    chk(32'(uart_far_end_inst.got_q.size()), 32'(n));
    // a far end that never collects is a hang: stop here rather than run on
    if (uart_far_end_inst.got_q.size() < n) begin
      fails++;
      report_and_stop();
    end
  endtask

  task automatic set_stall(input logic s);
    @(posedge sys_clk);
    stall <= s;
  endtask

  initial begin
    {psel, penable, pwrite, stall, reset_n} = 5'h00;
    paddr  = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    fails  = 0;
    n_checks = 0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(ALIAS_12_ADDR, 32'h0000_0000);
    rd(LINE_STATUS_ADDR, 32'h0000_0020);
    $display("test reset done");

    send(1'b0, 8'hA5);
    rd(ALIAS_13_ADDR, 32'h0000_00A5);
    rd(LINE_STATUS_ADDR, 32'h0000_0020);
    send(1'b0, 8'h11);
    send(1'b0, 8'h22);
    rd(LINE_STATUS_ADDR, 32'h0000_0023);
    rd(ALIAS_12_ADDR, 32'h0000_0022);
    wr(CTRL_ADDR, 32'h0000_0002);
    send(1'b1, 8'hC3);
    rd(ALIAS_BASE_ADDR, 32'h0000_00C3);
    // upper write bits must not leak onto the line
    wr(ALIAS_12_ADDR, 32'hFFFF_FF5A);
    wait_got(1);
    chk({23'h0, uart_far_end_inst.got_q[0]}, 32'h0000_015A);
    $display("test receive and infrared done");

    wr(CTRL_ADDR, 32'h0000_0000);
    uart_far_end_inst.got_q.delete();
    set_stall(1'b1);
    wr(ALIAS_12_ADDR, 32'h0000_0041);
    wr(ALIAS_13_ADDR, 32'h0000_0042);
    rd(LINE_STATUS_ADDR, 32'h0000_0000);
    wr(ALIAS_12_ADDR, 32'h0000_0043);
    set_stall(1'b0);
    wait_got(2);
    chk({23'h0, uart_far_end_inst.got_q[0]}, 32'h0000_0041);
    chk({23'h0, uart_far_end_inst.got_q[1]}, 32'h0000_0043);
    rd(LINE_STATUS_ADDR, 32'h0000_0020);
    $display("test holding register done");

    wr(CTRL_ADDR, 32'h0000_0001);
    for (k = 0; k <= DEPTH; k++) send(1'b0, 8'(8'h10 + k));
    rd(LINE_STATUS_ADDR, 32'h0000_0023);
    for (k = 0; k < DEPTH; k++) rd(ALIAS_BASE_ADDR + 32'(4 * k), 32'(8'h10 + k));
    rd(LINE_STATUS_ADDR, 32'h0000_0020);
    uart_far_end_inst.got_q.delete();
    set_stall(1'b1);
    // one char sits in the output stage, DEPTH in the fifo, the last is lost
    for (k = 0; k <= DEPTH + 1; k++) wr(ALIAS_12_ADDR, 32'(8'h30 + k));
    rd(LINE_STATUS_ADDR, 32'h0000_0000);
    set_stall(1'b0);
    wait_got(DEPTH + 1);
    for (k = 0; k <= DEPTH; k++) chk(32'(uart_far_end_inst.got_q[k]), 32'(8'h30 + k));
    repeat (20) @(posedge sys_clk);
    chk(32'(uart_far_end_inst.got_q.size()), 32'(DEPTH + 1));
    $display("test fifo done");

    // data-ready rise, overrun and holding-empty rise have all happened by now
    rd(IRQ_STATUS_ADDR, 32'h0000_0007);
    wr(IRQ_STATUS_ADDR, 32'h0000_0007);
    rd(IRQ_STATUS_ADDR, 32'h0000_0000);
    wr(IRQ_MASK_ADDR, 32'h0000_0000);
    send(1'b0, 8'h77);
    repeat (4) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(IRQ_MASK_ADDR, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(IRQ_STATUS_ADDR, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b0, ALIAS_BASE_ADDR + ALIAS_SPAN, 32'h0000_0000);
    chk({31'h0, serr}, 32'h0000_0001);
    chk(rdata, 32'h0000_0000);
    $display("test interrupt and decode done");
    report_and_stop();
  end
endmodule
